// *** hdl/sspsc_pkg.sv ***
// Package: register map, field positions and shared types of the serial port status/control block
package sspsc_pkg;

  localparam logic [7:0] CTRL_IDX = 8'h11;
  localparam logic [7:0] STAT_IDX = 8'h13;
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
  localparam logic [11:0] EVT_ADDR = 12'h080;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // Event register bits (software writes one to pulse)
  localparam int EV_RX_BYTE = 0;
  localparam int EV_BUF_READ = 1;
  localparam int EV_BUF_WRITE = 2;

  localparam int ST_SMP = 7;
  localparam int ST_CKE = 6;
  localparam int ST_DA = 5;
  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_RW = 2;
  localparam int ST_UA = 1;
  localparam int ST_BF = 0;
  localparam int CT_WRITE_COLLISION_FLAG = 7;
  localparam int CT_OV = 6;
  localparam int CT_EN = 5;
  localparam int CT_CKP = 4;

  localparam logic [3:0] M_SPI_M4 = 4'h0;
  localparam logic [3:0] M_SPI_M16 = 4'h1;
  localparam logic [3:0] M_SPI_M64 = 4'h2;
  localparam logic [3:0] M_SPI_MTMR = 4'h3;
  localparam logic [3:0] M_SPI_S_SS = 4'h4;
  localparam logic [3:0] M_SPI_S = 4'h5;
  localparam logic [3:0] M_I2C_S7 = 4'h6;
  localparam logic [3:0] M_I2C_S10 = 4'h7;
  localparam logic [3:0] M_I2C_M = 4'h8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded operating mode
  typedef struct packed {
    logic spi;
    logic i2c;
    logic master;
    logic slave;
    logic ten_bit;
    logic ss_enable;
    logic [1:0] clk_div_sel;
    logic reserved;
  } sspsc_mode_t;

  // Serial engine events (one-cycle pulses from the datapath, plus the shifting and bus_idle levels)
  typedef struct packed {
    logic start_seen;
    logic stop_seen;
    logic ack_seen;
    logic addr_match;
    logic addr_rw;
    logic byte_is_data;
    logic byte_done;
    logic rx_byte;
    logic tx_start;
    logic tx_done;
    logic need_addr_update;
    logic shifting;
    logic bus_idle;
  } sspsc_evt_t;

  // Pin control and configuration toward the pads
  typedef struct packed {
    logic spi_pins_own;
    logic i2c_pins_own;
    logic sck_idle_high;
    logic tx_on_rising;
    logic sample_at_end;
    logic slew_ctrl_en;
    logic scl_hold_low;
  } sspsc_pin_t;

endpackage

// *** hdl/sspsc_top.sv ***
// Status and first control register of the synchronous serial port, AXI4-Lite slave
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sspsc_top (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire sspsc_pkg::sspsc_evt_t  evt,
  output sspsc_pkg::sspsc_mode_t      mode,
  output sspsc_pkg::sspsc_pin_t       pins,
  output logic                        buf_write_ok,
  output logic                        port_enabled
);
  import sspsc_pkg::*;

  logic [7:0] ctrl_q;
  logic [1:0] phase_edge_q;
  logic       da_q, stop_q, start_q, rw_q, ua_q, bf_q, txbusy_q;
  logic       aw_held_q, w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic       en;
  logic       do_write, do_read;
  logic       wr_ctrl, wr_stat, wr_evt, addr_ok;
  logic       sw_rx, sw_read, sw_write;
  logic       rx_any, wr_any, collide;
  logic [7:0] stat_v;
  logic [31:0] rd_v;

  assign en = ctrl_q[CT_EN];

  // Mode decode
  always_comb begin
    mode = '0;
    unique case (ctrl_q[3:0])
      M_SPI_M4, M_SPI_M16, M_SPI_M64, M_SPI_MTMR: begin
        mode.spi = 1'b1;
        mode.master = 1'b1;
        mode.clk_div_sel = ctrl_q[1:0];
      end
      M_SPI_S_SS, M_SPI_S: begin
        mode.spi = 1'b1;
        mode.slave = 1'b1;
        mode.ss_enable = (ctrl_q[3:0] == M_SPI_S_SS);
      end
      M_I2C_S7, M_I2C_S10: begin
        mode.i2c = 1'b1;
        mode.slave = 1'b1;
        mode.ten_bit = (ctrl_q[3:0] == M_I2C_S10);
      end
      M_I2C_M: begin
        mode.i2c = 1'b1;
        mode.master = 1'b1;
      end
      default: mode.reserved = 1'b1;
    endcase
  end

  // AXI write channel capture, either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  assign addr_ok = (awaddr_q[11:2] == CTRL_ADDR[11:2]) || (awaddr_q[11:2] == STAT_ADDR[11:2])
                   || (awaddr_q[11:2] == EVT_ADDR[11:2]);
  assign wr_ctrl = do_write && wstrb_q[0] && (awaddr_q[11:2] == CTRL_ADDR[11:2]);
  assign wr_stat = do_write && wstrb_q[0] && (awaddr_q[11:2] == STAT_ADDR[11:2]);
  assign wr_evt  = do_write && wstrb_q[0] && (awaddr_q[11:2] == EVT_ADDR[11:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software events: received byte from the shifter, buffer read, buffer write
  assign sw_rx    = wr_evt && wdata_q[EV_RX_BYTE];
  assign sw_read  = wr_evt && wdata_q[EV_BUF_READ];
  assign sw_write = wr_evt && wdata_q[EV_BUF_WRITE];
  assign rx_any   = en && (evt.rx_byte || sw_rx);
  assign wr_any   = en && sw_write;

  // Collision: master while bus not idle, slave while shifting
  assign collide = wr_any && ((mode.master && (!evt.bus_idle || txbusy_q))
                   || (mode.slave && (evt.shifting || (mode.i2c && bf_q && txbusy_q))));
  assign buf_write_ok = wr_any && !collide;

  // Control register; hardware sets win over software clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0];
      end
      if (collide) begin
        ctrl_q[CT_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (rx_any && bf_q && mode.slave && mode.spi) begin
        ctrl_q[CT_OV] <= 1'b1;
      end
      if (rx_any && bf_q && mode.i2c && !txbusy_q) begin
        ctrl_q[CT_OV] <= 1'b1;
      end
    end
  end

  // Software-writable status bits only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_edge_q <= STAT_RESET[ST_SMP:ST_CKE];
    end else if (wr_stat) begin
      phase_edge_q <= wdata_q[ST_SMP:ST_CKE];
    end
  end

  // Start and stop tracking, cleared while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !en || !mode.i2c) begin
      stop_q  <= 1'b0;
      start_q <= 1'b0;
    end else if (evt.stop_seen) begin
      stop_q  <= 1'b1;
      start_q <= 1'b0;
    end else if (evt.start_seen) begin
      start_q <= 1'b1;
      stop_q  <= 1'b0;
    end
  end

  // Data/address and address update
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      da_q <= 1'b0;
      ua_q <= 1'b0;
    end else begin
      if (mode.i2c && mode.slave && evt.byte_done) begin
        da_q <= evt.byte_is_data;
      end
      if (mode.i2c && mode.ten_bit && evt.need_addr_update) begin
        ua_q <= 1'b1;
      end else if (sw_read) begin
        ua_q <= 1'b0;
      end
    end
  end

  // Transmit in progress tracking
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      txbusy_q <= 1'b0;
    end else if (evt.tx_start || buf_write_ok) begin
      txbusy_q <= 1'b1;
    end else if (evt.tx_done) begin
      txbusy_q <= 1'b0;
    end
  end

  // Direction flag: slave read bit, master transmit busy
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      rw_q <= 1'b0;
    end else if (mode.i2c && mode.master) begin
      rw_q <= txbusy_q;
    end else if (mode.i2c && mode.slave) begin
      if (evt.addr_match) begin
        rw_q <= evt.addr_rw;
      end else if (evt.start_seen || evt.stop_seen || evt.ack_seen) begin
        rw_q <= 1'b0;
      end
    end
  end

  // Buffer full: receive fills, read empties; I2C transmit holds until byte sent
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      bf_q <= 1'b0;
    end else if (rx_any) begin
      bf_q <= 1'b1;
    end else if (mode.i2c && buf_write_ok) begin
      bf_q <= 1'b1;
    end else if (mode.i2c && evt.tx_done) begin
      bf_q <= 1'b0;
    end else if (sw_read) begin
      bf_q <= 1'b0;
    end
  end

  assign stat_v = {phase_edge_q, da_q, stop_q, start_q, rw_q, ua_q, bf_q};

  // Pin ownership and clocking configuration
  always_comb begin
    pins = '0;
    pins.spi_pins_own  = en && mode.spi;
    pins.i2c_pins_own  = en && mode.i2c;
    pins.sck_idle_high = mode.spi && ctrl_q[CT_CKP];
    pins.tx_on_rising  = phase_edge_q[0] ^ ctrl_q[CT_CKP];
    pins.sample_at_end = mode.spi && mode.master && phase_edge_q[1];
    pins.slew_ctrl_en  = mode.i2c && !phase_edge_q[1];
    pins.scl_hold_low  = en && mode.i2c && mode.slave && !ctrl_q[CT_CKP];
  end
  assign port_enabled = en;

  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_v = '0;
    if (s_axi_araddr[11:2] == CTRL_ADDR[11:2]) begin
      rd_v[7:0] = ctrl_q;
    end else if (s_axi_araddr[11:2] == STAT_ADDR[11:2]) begin
      rd_v[7:0] = stat_v;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_v;
      s_axi_rresp  <= ((s_axi_araddr[11:2] == CTRL_ADDR[11:2]) || (s_axi_araddr[11:2] == STAT_ADDR[11:2])
                       || (s_axi_araddr[11:2] == EVT_ADDR[11:2])) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** test/sspsc_engine_model.sv ***
// Behavioural serial engine that raises datapath events
`timescale 1ns/1ps
`default_nettype none
module sspsc_engine_model
  import sspsc_pkg::*;
(
  input  wire logic aclk,
  output var sspsc_evt_t evt
);
  initial begin
    evt = '0;
    evt.bus_idle = 1'b1;
  end

  // One-cycle strobes, launched just after an edge
  task automatic pulse(input sspsc_evt_t e);
    @(posedge aclk);
    evt <= sspsc_evt_t'(evt | e);
    @(posedge aclk);
    evt <= sspsc_evt_t'(evt & ~e);
  endtask

  task automatic hold(input logic sh, input logic idle);
    @(posedge aclk);
    evt.shifting <= sh;
    evt.bus_idle <= idle;
  endtask
endmodule
`default_nettype wire

// *** test/sspsc_assertions.sv ***
// Port-level checker for the serial port status/control block
`timescale 1ns/1ps
`default_nettype none
module sspsc_assertions
  import sspsc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire sspsc_evt_t  evt,
  input wire sspsc_mode_t mode,
  input wire sspsc_pin_t  pins,
  input wire logic        buf_write_ok,
  input wire logic        port_enabled
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_ctrl;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == CTRL_ADDR && s_axi_wstrb[0];
  endsequence

  // Write lands one cycle after both halves are taken, response with it
  chk_ctrl_enable: assert property (wr_ctrl |-> ##2 port_enabled == $past(s_axi_wdata[5], 2))
    else $error("enable bit not taken from write");
  chk_write_resp: assert property (wr_ctrl |=> ##1 s_axi_bvalid)
    else $error("write response late");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  chk_spi_pins: assert property (pins.spi_pins_own == (port_enabled && mode.spi))
    else $error("SPI pin ownership wrong");
  chk_i2c_pins: assert property (pins.i2c_pins_own == (port_enabled && mode.i2c))
    else $error("I2C pin ownership wrong");
  chk_slave_write_collision_flag: assert property (mode.slave && evt.shifting |-> !buf_write_ok)
    else $error("slave write accepted while shifting");
  chk_master_write_collision_flag: assert property (mode.master && !evt.bus_idle |-> !buf_write_ok)
    else $error("master write accepted on busy bus");
endmodule

bind sspsc_top sspsc_assertions u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .evt, .mode,
  .pins, .buf_write_ok, .port_enabled
);
`default_nettype wire

// *** test/sync_serial_port_status_control_tb.sv ***
// Self-checking bench for the serial port status/control block
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_status_control_tb;
  import sspsc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, buf_write_ok, port_enabled;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  sspsc_evt_t  evt;
  sspsc_mode_t mode;
  sspsc_pin_t  pins;
  int          num_errors = 0, checks = 0;
  logic [11:0] ra [4] = '{CTRL_ADDR, STAT_ADDR, STAT_ADDR, 12'h100};
  logic [31:0] rw [4] = '{32'h36, 32'hFF, 32'h00, 32'h5A};
  logic [31:0] rx [4] = '{32'h36, 32'hC0, 32'h00, 32'h00};
  logic [1:0]  rr [4] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};

  always #10 aclk = ~aclk;

  sspsc_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt, .mode, .pins, .buf_write_ok, .port_enabled
  );
  sspsc_engine_model partner (.aclk, .evt);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    q = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(q & m, e);
  endtask

  initial begin
    logic [5:0] e;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CTRL_ADDR, 32'hFFFFFFFF, {24'h0, CTRL_RESET});
    rc(STAT_ADDR, 32'hFFFFFFFF, {24'h0, STAT_RESET});
    for (int i = 0; i < 4; i++) begin
      wr(ra[i], rw[i]);
      chk(32'(r), 32'(rr[i]));
      rd(ra[i]);
      chk(q, rx[i]);
      chk(32'(r), 32'(rr[i]));
    end
    for (int i = 0; i < 10; i++) begin
      wr(CTRL_ADDR, 32'h20 | 32'(i));
      e = {i < 6, i inside {[6:8]}, i < 4 || i == 8, i > 8, i < 6, i inside {[6:8]}};
      chk(32'({mode.spi, mode.i2c, mode.master, mode.reserved, pins.spi_pins_own, pins.i2c_pins_own}), 32'(e));
    end
    // Ten-bit I2C slave: condition and address tracking
    wr(CTRL_ADDR, 32'h37);
    partner.pulse('{start_seen: 1'b1, default: 1'b0});
    rc(STAT_ADDR, 32'h18, 32'h08);
    partner.pulse('{stop_seen: 1'b1, default: 1'b0});
    rc(STAT_ADDR, 32'h18, 32'h10);
    partner.pulse('{addr_match: 1'b1, addr_rw: 1'b1, need_addr_update: 1'b1, default: 1'b0});
    rc(STAT_ADDR, 32'h06, 32'h06);
    partner.pulse('{byte_done: 1'b1, byte_is_data: 1'b1, default: 1'b0});
    rc(STAT_ADDR, 32'h20, 32'h20);
    partner.pulse('{rx_byte: 1'b1, default: 1'b0});
    rc(STAT_ADDR, 32'h01, 32'h01);
    partner.pulse('{rx_byte: 1'b1, default: 1'b0});
    rc(CTRL_ADDR, 32'h40, 32'h40);
    wr(EVT_ADDR, 32'h2);
    rc(STAT_ADDR, 32'h01, 32'h00);
    wr(CTRL_ADDR, 32'h37);
    rc(CTRL_ADDR, 32'hFF, 32'h37);
    wr(CTRL_ADDR, 32'h17);
    rc(STAT_ADDR, 32'h38, 32'h00);
    // SPI master: no overflow, busy bus collides
    wr(CTRL_ADDR, 32'h30);
    partner.pulse('{rx_byte: 1'b1, default: 1'b0});
    partner.pulse('{rx_byte: 1'b1, default: 1'b0});
    rc(CTRL_ADDR, 32'h40, 32'h00);
    partner.hold(1'b0, 1'b0);
    wr(EVT_ADDR, 32'h4);
    rc(CTRL_ADDR, 32'h80, 32'h80);
    partner.hold(1'b0, 1'b1);
    wr(STAT_ADDR, 32'hC0);
    chk(32'({pins.sck_idle_high, pins.tx_on_rising, pins.sample_at_end}), 32'h5);
    // SPI slave: overflow and collision while shifting
    wr(STAT_ADDR, 32'h40);
    wr(CTRL_ADDR, 32'h25);
    wr(EVT_ADDR, 32'h2);
    wr(EVT_ADDR, 32'h1);
    partner.pulse('{rx_byte: 1'b1, default: 1'b0});
    rc(CTRL_ADDR, 32'h40, 32'h40);
    partner.hold(1'b1, 1'b1);
    wr(EVT_ADDR, 32'h4);
    rc(CTRL_ADDR, 32'h80, 32'h80);
    partner.hold(1'b0, 1'b1);
    // I2C master: transmit busy, buffer full while sending
    wr(CTRL_ADDR, 32'h28);
    wr(EVT_ADDR, 32'h2);
    wr(EVT_ADDR, 32'h4);
    rc(CTRL_ADDR, 32'h80, 32'h00);
    rc(STAT_ADDR, 32'h05, 32'h05);
    wr(EVT_ADDR, 32'h4);
    rc(CTRL_ADDR, 32'h80, 32'h80);
    partner.pulse('{tx_done: 1'b1, default: 1'b0});
    rc(STAT_ADDR, 32'h05, 32'h00);
    // I2C slave clock stretch and slew
    wr(CTRL_ADDR, 32'h26);
    wr(STAT_ADDR, 32'h80);
    chk(32'({pins.scl_hold_low, pins.slew_ctrl_en}), 32'h2);
    complete_run();
  end

  initial begin
    #1000000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
